// ### verilog/sdl_pkg.sv
// Constants and carrier types for the serial converter load interface
`default_nettype none

package sdl_pkg;

  // ------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------
  localparam int unsigned CODE_W   = 16;
  localparam int unsigned CODE_MSB = 15;
  localparam int unsigned CODE_LSB = 0;
  localparam int unsigned FULL_SCALE_DIV = 65536;
  localparam logic [15:0] CODE_RESET     = 16'h0000;
  localparam logic [15:0] CODE_FULL      = 16'hFFFF;
  localparam logic [4:0]  CNT_RESET      = 5'h00;
  localparam logic [4:0]  CNT_FULL       = 5'h10;

  typedef logic [CODE_W-1:0] sdl_code_t;

  // Frame carried from the link domain to the system domain
  typedef struct packed {
    sdl_code_t  code;
    logic [4:0] bits;
  } sdl_frame_s;

endpackage

`default_nettype wire

// ### verilog/sdl_link_shift.sv
// Link-domain shift register and saturating bit counter on serial clock
`default_nettype none

module sdl_link_shift
  import sdl_pkg::*;
(
  input  wire logic       link_clk_in,
  input  wire logic       link_rstn_in,
  input  wire logic       select_n_in,
  input  wire logic       serial_data_in,
  output var  sdl_frame_s shift_out
);

  sdl_code_t  shreg;
  logic [4:0] bit_cnt;

  // Shift in while selected, MSB first, oldest surplus falls off the top
  always_ff @(posedge link_clk_in or negedge link_rstn_in) begin
    if (!link_rstn_in) begin
      shreg <= CODE_RESET;
    end else if (!select_n_in) begin
      shreg <= {shreg[CODE_MSB-1:CODE_LSB], serial_data_in};
    end
  end

  // Count bits shifted since link reset (never cleared between frames), saturating at sixteen
  always_ff @(posedge link_clk_in or negedge link_rstn_in) begin
    if (!link_rstn_in) begin
      bit_cnt <= CNT_RESET;
    end else if (!select_n_in && bit_cnt != CNT_FULL) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  assign shift_out = '{code: shreg, bits: bit_cnt};

  a_shift_order: assert property (@(posedge link_clk_in) disable iff (!link_rstn_in)
    !select_n_in |=> shreg[0] == $past(serial_data_in) &&
      shreg[CODE_MSB:1] == $past(shreg[CODE_MSB-1:0]))
    else $error("shift order wrong");
  a_shift_hold: assert property (@(posedge link_clk_in) disable iff (!link_rstn_in)
    select_n_in |=> $stable(shreg))
    else $error("shift moved while deselected");

endmodule

`default_nettype wire

// ### verilog/sdl_load_top.sv
// Serial converter load interface: link shift and select-edge code latch
`default_nettype none

module sdl_load_top
  import sdl_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rstn_in,
  input  wire logic      link_clk_in,
  input  wire logic      select_n_in,
  input  wire logic      serial_data_in,
  output var  sdl_code_t ladder_code_out,
  output logic           code_loaded_out
);

  // ------------------------------------------------------------
  // Link-domain reset synchroniser
  // ------------------------------------------------------------
  logic link_rst_meta;
  logic link_rstn;

  // Async assert, sync release on the link clock
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_rst_meta <= 1'b0;
      link_rstn     <= 1'b0;
    end else begin
      link_rst_meta <= 1'b1;
      link_rstn     <= link_rst_meta;
    end
  end

  // ------------------------------------------------------------
  // Link-side shifter
  // ------------------------------------------------------------
  sdl_frame_s link_frame;

  sdl_link_shift u_shift (
    .link_clk_in    (link_clk_in),
    .link_rstn_in   (link_rstn),
    .select_n_in    (select_n_in),
    .serial_data_in (serial_data_in),
    .shift_out      (link_frame)
  );

  // ------------------------------------------------------------
  // Select synchroniser and edge detect in system domain
  // ------------------------------------------------------------
  logic sel_meta;
  logic sel_sync;
  logic sel_prev;
  logic sel_rise;

  // Two flops on the asynchronous select pin
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_meta <= 1'b1;
      sel_sync <= 1'b1;
    end else begin
      sel_meta <= select_n_in;
      sel_sync <= sel_meta;
    end
  end

  // Delayed copy for edge detection
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_prev <= 1'b1;
    end else begin
      sel_prev <= sel_sync;
    end
  end

  assign sel_rise = sel_sync && !sel_prev;

  // ------------------------------------------------------------
  // Code register
  // ------------------------------------------------------------
  // Shift word is static once select is high (link clock has no effect),
  // so it is safe to sample one clock after the synchronised edge.
  sdl_code_t next_code;
  assign next_code = link_frame.code;

  // Latch the frame on select rise, hold otherwise
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ladder_code_out <= CODE_RESET;
    end else if (sel_rise) begin
      ladder_code_out <= next_code;
    end
  end

  // One-cycle pulse marking a fresh load
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      code_loaded_out <= 1'b0;
    end else begin
      code_loaded_out <= sel_rise;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_code_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !sel_rise |=> $stable(ladder_code_out))
    else $error("code changed without select rise");
  a_code_load: assert property (@(posedge clk_in) disable iff (!rstn_in)
    sel_rise |=> ladder_code_out == $past(next_code) && code_loaded_out)
    else $error("code not loaded on select rise");
  a_pulse_single: assert property (@(posedge clk_in) disable iff (!rstn_in)
    code_loaded_out |=> !code_loaded_out)
    else $error("load pulse too long");
  // Only the second synchroniser flop is watched, never the metastable one
  a_rise_latency: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(sel_sync) |-> sel_rise)
    else $error("select rise missed");
  a_hold_deselect: assert property (@(posedge clk_in) disable iff (!rstn_in)
    sel_sync && sel_prev |=> $stable(ladder_code_out))
    else $error("code moved while deselected");
  a_zero_start: assert property (@(posedge clk_in)
    $rose(rstn_in) |-> ladder_code_out == CODE_RESET)
    else $error("code not zero after reset");
  a_width_ok: assert property (@(posedge clk_in) disable iff (!rstn_in)
    sel_rise |=> ladder_code_out[CODE_MSB] == $past(next_code[CODE_MSB]))
    else $error("msb misplaced");
  a_full_scale: assert property (@(posedge clk_in) disable iff (!rstn_in)
    sel_rise && next_code == CODE_FULL |=> ladder_code_out == CODE_FULL)
    else $error("full scale not loaded");

  c_load: cover property (@(posedge clk_in) disable iff (!rstn_in) sel_rise);
  c_full: cover property (@(posedge clk_in) disable iff (!rstn_in)
    code_loaded_out && ladder_code_out == CODE_FULL);
  c_two_loads: cover property (@(posedge clk_in) disable iff (!rstn_in)
    code_loaded_out ##[1:200] code_loaded_out);
  // Loads once sixteen or more bits have been shifted since link reset
  c_full_frame: cover property (@(posedge clk_in) disable iff (!rstn_in)
    sel_rise && link_frame.bits == CNT_FULL);
  c_zero_load: cover property (@(posedge clk_in) disable iff (!rstn_in)
    code_loaded_out && ladder_code_out == CODE_RESET);

endmodule

`default_nettype wire

// ### verif/sdl_host_model.sv
// Host-side serial master model for the three-wire load bus
`default_nettype none

module sdl_host_model;
  timeunit 1ns;
  timeprecision 1ps;

  logic link_clk = 1'b0;
  logic select_n = 1'b1;
  logic sdata    = 1'b0;

  // One clock pulse; data set while the clock is low
  task automatic tick(input logic bit_val);
    sdata = bit_val;
    #6 link_clk = 1'b1;
    #6 link_clk = 1'b0;
  endtask

  // Whole frame, top bit first, select raised to load
  task automatic send(input logic [31:0] word, input int nbits);
    select_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      tick(word[i]);
    end
    #10 select_n = 1'b1;
    sdata = ~sdata;  // Released line shows the inverse
  endtask
endmodule

`default_nettype wire

// ### verif/sdl_load_top_tb.sv
// Self-checking bench for the serial converter load interface
`default_nettype none

module sdl_load_top_tb;
  import sdl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic      clk_in       = 1'b0;
  logic      rstn_in      = 1'b0;
  sdl_code_t code;
  logic      loaded;
  int        err_count    = 0;
  int        total_checks = 0;

  sdl_host_model host_u ();

  sdl_load_top dut_u (
    .clk_in          (clk_in),
    .rstn_in         (rstn_in),
    .link_clk_in     (host_u.link_clk),
    .select_n_in     (host_u.select_n),
    .serial_data_in  (host_u.sdata),
    .ladder_code_out (code),
    .code_loaded_out (loaded)
  );

  // System clock, 10 ns
  initial begin
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Send a frame, hold check mid-frame, then await the load pulse
  task automatic frame(input logic [31:0] word, input int nbits, input sdl_code_t exp);
    sdl_code_t old;
    int        n;
    old = code;
    n = 0;
    fork
      host_u.send(word, nbits);
      begin
        repeat (nbits) @(negedge clk_in);
        check(code, old);
      end
    join
    while (loaded !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    check(16'(n <= 6), 16'h0001);
    check(code, exp);
    @(negedge clk_in);
    check({15'h0000, loaded}, 16'h0000);
    $display("frame of %0d bits done", nbits);
  endtask

  // Clocks with select high leave shift word and code alone
  task automatic idle_clocks();
    repeat (4) host_u.tick(1'b1);
    repeat (6) @(negedge clk_in);
    check(code, 16'h1234);
    $display("idle clock test done");
  endtask

  initial begin
    repeat (6) @(negedge clk_in);
    check(code, CODE_RESET);
    check({15'h0000, loaded}, 16'h0000);
    rstn_in = 1'b1;
    host_u.tick(1'b0);
    host_u.tick(1'b0);
    $display("reset test done");
    frame(32'h0000_A5C3, 16, 16'hA5C3);
    frame(32'h000F_1234, 20, 16'h1234);
    idle_clocks();
    frame(32'h0000_00AB, 8, 16'h34AB);
    frame(32'h0000_FFFF, 16, CODE_FULL);
    frame(32'h0000_0000, 16, CODE_RESET);
    wrap_up();
  end

  // Watchdog well past the expected run time
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
endmodule

`default_nettype wire
